// *** lmpc_top.sv ***
// lmpc_top: front panel control of a load module, single or dual channel panel
// assumes asynchronous key and knob pins, axi4-lite register access on clk, sys_rst synchronous
`timescale 1ns/1ps

module lmpc_top #(
  parameter int unsigned long_press = lmpc_pkg::long_press_cycles,
  parameter int unsigned debounce = lmpc_pkg::debounce_cycles,
  parameter int unsigned blink = lmpc_pkg::blink_cycles,
  parameter int unsigned digits = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // panel pins
  input wire lmpc_pkg::lmpc_keys_type key_pins,
  input wire logic knob_a,
  input wire logic knob_b,
  output lmpc_pkg::lmpc_leds_type leds,
  output logic [2:0] digit_cursor,
  output logic digit_blink_on,
  output lmpc_pkg::lmpc_disp_type display_quantity,
  output lmpc_pkg::lmpc_chan_type channel_sel,
  // load stage controls
  output logic [1:0] input_on,
  output logic [1:0] short_on,
  output logic [1:0] dynamic_on,
  output logic [1:0] level_two,
  output logic protection_test_start,
  output logic [15:0] local_level,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] ctrl;
  logic [15:0] level_setting;
  logic [1:0] limit_pass;
  logic level_written;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic w_held;
  logic [31:0] status_word;

  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign do_write = (aw_held | (s_axi_awvalid & s_axi_awready)) & (w_held | (s_axi_wvalid & s_axi_wready));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  logic [3:0] use_strb;
  assign use_strb = w_held ? w_strb : s_axi_wstrb;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= lmpc_pkg::ctrl_reset;
      level_setting <= lmpc_pkg::level_reset;
      limit_pass <= '0;
      level_written <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lmpc_pkg::resp_okay;
    end else begin
      level_written <= 1'b0;
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= lmpc_pkg::resp_okay;
        if (wr_addr == lmpc_pkg::ctrl_offset) begin
          ctrl <= strobe_merge(ctrl, wr_data, use_strb);
        end else if (wr_addr == lmpc_pkg::level_offset) begin
          level_setting <= 16'(strobe_merge({16'h0000, level_setting}, wr_data, use_strb));
          level_written <= 1'b1;
        end else if (wr_addr == lmpc_pkg::limit_offset) begin
          limit_pass <= wr_data[1:0];
        end else if (wr_addr != lmpc_pkg::status_offset) begin
          s_axi_bresp <= lmpc_pkg::resp_slverr;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= lmpc_pkg::decerr_data;
      s_axi_rresp <= lmpc_pkg::resp_okay;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= lmpc_pkg::resp_okay;
      if (s_axi_araddr == lmpc_pkg::ctrl_offset) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == lmpc_pkg::level_offset) begin
        s_axi_rdata <= {16'h0000, local_level};
      end else if (s_axi_araddr == lmpc_pkg::status_offset) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr == lmpc_pkg::limit_offset) begin
        s_axi_rdata <= {30'h0000_0000, limit_pass};
      end else begin
        s_axi_rdata <= lmpc_pkg::decerr_data;
        s_axi_rresp <= lmpc_pkg::resp_slverr;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic dual;
  logic remap;
  logic momentary;
  logic test_mode;
  logic limit_on;
  lmpc_pkg::lmpc_mode_type op_mode;
  assign dual = ctrl[lmpc_pkg::ctrl_dual_bit];
  assign remap = ctrl[lmpc_pkg::ctrl_remap_bit];
  assign momentary = ctrl[lmpc_pkg::ctrl_momentary_bit];
  assign test_mode = ctrl[lmpc_pkg::ctrl_ocp_bit] | ctrl[lmpc_pkg::ctrl_opp_bit];
  assign limit_on = ctrl[lmpc_pkg::ctrl_limit_on_bit];
  assign op_mode = lmpc_pkg::lmpc_mode_type'(ctrl[lmpc_pkg::ctrl_mode_lsb +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // keys and knob inputs
  logic [3:0] key_level;
  logic [3:0] key_press;
  logic [3:0] key_release;
  logic [3:0] key_raw;
  assign key_raw = key_pins;

  for (genvar k = 0; k < 4; k++) begin : g_key
    lmpc_debounce #(.stable_cycles(debounce)) u_db (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(key_raw[k]),
      .level(key_level[k]),
      .press(key_press[k]),
      .release_pulse(key_release[k])
    );
  end

  // index 3 select, 2 quantity, 1 short, 0 load
  logic knob_a_s0;
  logic knob_a_s1;
  logic knob_a_d;
  logic knob_b_s0;
  logic knob_b_s1;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      knob_a_s0 <= 1'b0;
      knob_a_s1 <= 1'b0;
      knob_a_d <= 1'b0;
      knob_b_s0 <= 1'b0;
      knob_b_s1 <= 1'b0;
    end else begin
      knob_a_s0 <= knob_a;
      knob_a_s1 <= knob_a_s0;
      knob_a_d <= knob_a_s1;
      knob_b_s0 <= knob_b;
      knob_b_s1 <= knob_b_s0;
    end
  end
  // one detent per rising edge of phase a; phase b decides the direction
  logic knob_step;
  logic knob_cw;
  assign knob_step = knob_a_s1 & ~knob_a_d;
  assign knob_cw = ~knob_b_s1;

  ////////////////////////////////////////////////////////////////////////////
  // long press timer on the select key
  logic [31:0] hold_count;
  logic long_fired;
  logic long_event;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_count <= '0;
      long_fired <= 1'b0;
    end else if (!key_level[3]) begin
      hold_count <= '0;
      long_fired <= 1'b0;
    end else if (!long_fired) begin
      if (hold_count >= 32'(long_press - 1)) begin
        long_fired <= 1'b1;
      end else begin
        hold_count <= hold_count + 32'd1;
      end
    end
  end
  assign long_event = key_level[3] & ~long_fired & (hold_count >= 32'(long_press - 1));
  // a short select press acts on release, so a long hold never also toggles
  logic select_short;
  assign select_short = key_release[3] & ~long_fired;

  ////////////////////////////////////////////////////////////////////////////
  // panel state
  logic both;
  logic ch;
  logic fixed_mode;
  assign both = (channel_sel != lmpc_pkg::lmpc_ch_l) && (channel_sel != lmpc_pkg::lmpc_ch_r);
  assign ch = dual && (channel_sel == lmpc_pkg::lmpc_ch_r);
  logic accept;
  assign accept = ~(dual & both);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_sel <= lmpc_pkg::lmpc_ch_l;
    end else if (dual && select_short && !fixed_mode) begin
      case (channel_sel)
        lmpc_pkg::lmpc_ch_l: channel_sel <= lmpc_pkg::lmpc_ch_r;
        lmpc_pkg::lmpc_ch_r: channel_sel <= lmpc_pkg::lmpc_ch_both_v;
        lmpc_pkg::lmpc_ch_both_v: channel_sel <= lmpc_pkg::lmpc_ch_both_i;
        lmpc_pkg::lmpc_ch_both_i: channel_sel <= lmpc_pkg::lmpc_ch_both_p;
        default: channel_sel <= lmpc_pkg::lmpc_ch_l;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input_on <= '0;
    end else if (accept && key_press[0]) begin
      input_on[ch] <= ~input_on[ch];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_two <= '0;
    end else if (dual) begin
      level_two <= '0;
    end else if (select_short && !fixed_mode) begin
      level_two[0] <= ~level_two[0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      display_quantity <= lmpc_pkg::lmpc_disp_v_i;
    end else if (accept && !remap && key_press[2]) begin
      case (display_quantity)
        lmpc_pkg::lmpc_disp_v_i: display_quantity <= lmpc_pkg::lmpc_disp_p_i;
        lmpc_pkg::lmpc_disp_p_i: display_quantity <= lmpc_pkg::lmpc_disp_v_p;
        default: display_quantity <= lmpc_pkg::lmpc_disp_v_i;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dynamic_on <= '0;
    end else if (accept && remap && !fixed_mode && key_press[2] && op_mode == lmpc_pkg::lmpc_cc) begin
      dynamic_on[ch] <= ~dynamic_on[ch];
    end
  end

  // short: toggle or momentary; any short drops when the input goes off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      short_on <= '0;
      protection_test_start <= 1'b0;
    end else begin
      protection_test_start <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        if (!input_on[c]) begin
          short_on[c] <= 1'b0;
        end
      end
      if (accept && input_on[ch]) begin
        if (key_press[1] && test_mode) begin
          protection_test_start <= 1'b1;
        end else if (momentary && !test_mode) begin
          short_on[ch] <= key_level[1];
        end else if (key_press[1] && !test_mode) begin
          short_on[ch] <= ~short_on[ch];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed digit mode and knob
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fixed_mode <= 1'b0;
      digit_cursor <= '0;
    end else if (accept && long_event && (input_on[ch] || fixed_mode)) begin
      fixed_mode <= ~fixed_mode;
      digit_cursor <= '0;
    end else if (fixed_mode && accept) begin
      if (select_short && digit_cursor < 3'(digits - 1)) begin
        digit_cursor <= digit_cursor + 3'd1;
      end else if (key_press[2] && remap && digit_cursor != 3'd0) begin
        digit_cursor <= digit_cursor - 3'd1;
      end
    end
  end

  logic [24:0] blink_count;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_count <= '0;
      digit_blink_on <= 1'b0;
    end else if (!fixed_mode) begin
      blink_count <= '0;
      digit_blink_on <= 1'b0;
    end else if (blink_count >= 25'(blink - 1)) begin
      blink_count <= '0;
      digit_blink_on <= ~digit_blink_on;
    end else begin
      blink_count <= blink_count + 25'd1;
    end
  end

  function automatic logic [15:0] pow10(input logic [2:0] d);
    case (d)
      3'd0: return 16'h0001;
      3'd1: return 16'h000A;
      3'd2: return 16'h0064;
      3'd3: return 16'h03E8;
      default: return 16'h2710;
    endcase
  endfunction

  logic [15:0] step;
  assign step = fixed_mode ? pow10(digit_cursor) : 16'h0001;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      local_level <= lmpc_pkg::level_reset;
    end else if (level_written) begin
      local_level <= level_setting;
    end else if (accept && knob_step && input_on[ch]) begin
      if (knob_cw) begin
        local_level <= (local_level > 16'hFFFF - step) ? 16'hFFFF : local_level + step;
      end else begin
        local_level <= (local_level < step) ? 16'h0000 : local_level - step;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  logic pass_all;
  assign pass_all = (dual && both) ? &limit_pass : limit_pass[ch];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      leds <= '0;
    end else begin
      leds.select_led <= ~dual & ~level_two[0];
      leds.quantity_led <= remap & dynamic_on[ch] & accept;
      leds.short_led <= short_on[ch] & accept;
      leds.load_led <= dual ? |input_on : input_on[0];
      leds.mode_led <= accept ? (4'h1 << op_mode) : 4'h0;
      leds.pass_green <= limit_on & pass_all;
      leds.pass_red <= limit_on & ~pass_all;
      leds.chan_l_led <= dual & (channel_sel != lmpc_pkg::lmpc_ch_r);
      leds.chan_r_led <= dual & (channel_sel != lmpc_pkg::lmpc_ch_l);
    end
  end

  assign status_word = {17'h0_0000, fixed_mode, digit_cursor, channel_sel, display_quantity,
                        dynamic_on, short_on, input_on};

endmodule

// *** lmpc_pkg.sv ***
// lmpc_pkg: shared constants, types and field layouts of the load module panel control
// assumes a 125 MHz system clock and an axi4-lite register bus of 32-bit data
package lmpc_pkg;

  localparam int unsigned clk_hz = 125_000_000;
  localparam int unsigned long_press_ms = 2500;
  localparam int unsigned long_press_cycles = (clk_hz / 1000) * long_press_ms;
  localparam int unsigned debounce_us = 10_000;
  localparam int unsigned debounce_cycles = (clk_hz / 1_000_000) * debounce_us;
  localparam int unsigned blink_ms = 250;
  localparam int unsigned blink_cycles = (clk_hz / 1000) * blink_ms;

  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] level_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;
  localparam logic [7:0] limit_offset = 8'h0C;

  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [15:0] level_reset = 16'h0000;
  localparam logic [31:0] decerr_data = 32'h0000_0000;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // ctrl field positions
  localparam int unsigned ctrl_dual_bit = 0;
  localparam int unsigned ctrl_remap_bit = 1;
  localparam int unsigned ctrl_momentary_bit = 2;
  localparam int unsigned ctrl_ocp_bit = 3;
  localparam int unsigned ctrl_opp_bit = 4;
  localparam int unsigned ctrl_limit_on_bit = 5;
  localparam int unsigned ctrl_mode_lsb = 8;
  localparam int unsigned ctrl_write_level_bit = 12;

  // limit register fields: pass bit per channel
  localparam int unsigned limit_pass_l_bit = 0;
  localparam int unsigned limit_pass_r_bit = 1;

  typedef enum logic [1:0] {
    lmpc_cc = 2'b00,
    lmpc_cr = 2'b01,
    lmpc_cv = 2'b10,
    lmpc_cp = 2'b11
  } lmpc_mode_type;

  typedef enum logic [1:0] {
    lmpc_disp_v_i = 2'b00,
    lmpc_disp_p_i = 2'b01,
    lmpc_disp_v_p = 2'b10
  } lmpc_disp_type;

  typedef enum logic [2:0] {
    lmpc_ch_l = 3'b000,
    lmpc_ch_r = 3'b001,
    lmpc_ch_both_v = 3'b010,
    lmpc_ch_both_i = 3'b011,
    lmpc_ch_both_p = 3'b100
  } lmpc_chan_type;

  typedef struct packed {
    logic select_key;
    logic quantity_key;
    logic short_key;
    logic load_key;
  } lmpc_keys_type;

  typedef struct packed {
    logic select_led;
    logic quantity_led;
    logic short_led;
    logic load_led;
    logic [3:0] mode_led;
    logic pass_green;
    logic pass_red;
    logic chan_l_led;
    logic chan_r_led;
  } lmpc_leds_type;

endpackage

// *** lmpc_debounce.sv ***
// lmpc_debounce: synchronises and debounces one key pin, gives level and press and release pulses
// assumes key pins are asynchronous and active high
`timescale 1ns/1ps

module lmpc_debounce #(
  parameter int unsigned stable_cycles = lmpc_pkg::debounce_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw pin
  input wire logic pin,
  // debounced key
  output logic level,
  output logic press,
  output logic release_pulse
);

  logic sync_a;
  logic sync_b;
  logic [23:0] count;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // level changes only after the pin has held its new value for the whole window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
      level <= 1'b0;
      press <= 1'b0;
      release_pulse <= 1'b0;
    end else begin
      press <= 1'b0;
      release_pulse <= 1'b0;
      if (sync_b == level) begin
        count <= '0;
      end else if (count >= 24'(stable_cycles - 1)) begin
        count <= '0;
        level <= sync_b;
        press <= sync_b;
        release_pulse <= ~sync_b;
      end else begin
        count <= count + 24'd1;
      end
    end
  end

endmodule

// *** lmpc_top_props.sv ***
// lmpc_top_props: concurrent checks on the ports of lmpc_top
// assumes one clock domain, sys_rst synchronous active high; bound below
`timescale 1ns/1ps

module lmpc_top_props #(
  parameter int unsigned digits = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // panel side
  input wire lmpc_pkg::lmpc_leds_type leds,
  input wire logic [2:0] digit_cursor,
  input wire lmpc_pkg::lmpc_disp_type display_quantity,
  input wire lmpc_pkg::lmpc_chan_type channel_sel,
  input wire logic [1:0] input_on,
  input wire logic [1:0] short_on,
  input wire logic protection_test_start,
  // bus side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_taken;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence both_held;
    channel_sel >= lmpc_pkg::lmpc_ch_both_v && $past(channel_sel) >= lmpc_pkg::lmpc_ch_both_v;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // leds lag the state by one register stage
  chk_load_led_or: assert property (!$past(sys_rst) |-> leds.load_led == (|$past(input_on)))
    else $error("load led does not follow input state");
  chk_both_modes_off: assert property (both_held |-> leds.mode_led == 4'h0)
    else $error("mode leds lit with both channels selected");
  chk_disp_legal: assert property (display_quantity != 2'h3)
    else $error("display pairing out of range");
  chk_chan_step: assert property (channel_sel != $past(channel_sel) |->
    channel_sel == ($past(channel_sel) == 3'h4 ? 3'h0 : $past(channel_sel) + 3'h1))
    else $error("channel select skipped a state");
  chk_cursor_range: assert property (digit_cursor < digits)
    else $error("digit cursor beyond last digit");
  chk_pass_one_color: assert property (!(leds.pass_green && leds.pass_red))
    else $error("pass and fail lit together");
  chk_short_needs_on: assert property ($rose(short_on[0]) |-> input_on[0])
    else $error("short engaged with input off");
  chk_test_pulse: assert property (protection_test_start |=> !protection_test_start)
    else $error("protection start longer than one cycle");
  chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_done: assert property (b_taken |=> !s_axi_bvalid)
    else $error("write response not retired");
endmodule

bind lmpc_top lmpc_top_props #(.digits(digits)) u_props (.clk(clk), .sys_rst(sys_rst), .leds(leds),
  .digit_cursor(digit_cursor), .display_quantity(display_quantity), .channel_sel(channel_sel),
  .input_on(input_on), .short_on(short_on), .protection_test_start(protection_test_start),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// *** lmpc_panel_model.sv ***
// lmpc_panel_model: front panel keys and knob as seen by the control block
// assumes the caller waits long enough after a release for debounce to settle
`timescale 1ns/1ps

module lmpc_panel_model (
  // clock
  input wire logic clk,
  // panel pins
  output lmpc_pkg::lmpc_keys_type key_pins,
  output logic knob_a,
  output logic knob_b
);
  initial begin
    key_pins = '0;
    knob_a = 1'b0;
    knob_b = 1'b0;
  end

  task automatic set_key(input int k, input logic v);
    @(posedge clk) key_pins[k] <= v;
  endtask

  // idle after release so the next press is a fresh edge
  task automatic press(input int k, input int n);
    set_key(k, 1'b1);
    repeat (n) @(posedge clk);
    key_pins[k] <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  // one detent; b low means clockwise
  task automatic turn(input logic cw);
    @(posedge clk) knob_b <= !cw;
    @(posedge clk) knob_a <= 1'b1;
    repeat (6) @(posedge clk);
    knob_a <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** lmpc_top_test.sv ***
// lmpc_top_test: self-checking bench of lmpc_top with shortened counts
// assumes lmpc_panel_model on the pins and this bench as axi4-lite master
`timescale 1ns/1ps

module lmpc_top_test;
  logic clk, sys_rst, knob_a, knob_b, digit_blink_on, protection_test_start;
  lmpc_pkg::lmpc_keys_type key_pins;
  lmpc_pkg::lmpc_leds_type leds;
  lmpc_pkg::lmpc_disp_type display_quantity;
  lmpc_pkg::lmpc_chan_type channel_sel;
  logic [2:0] digit_cursor;
  logic [1:0] input_on, short_on, dynamic_on, level_two, s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] local_level;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0, compares = 0, prot = 0;
  // row: op [51:48] (0 ctrl write, 1 short press, 2 long press), arg, status mask, status expected
  logic [51:0] rows [25] = '{
    52'h0_0000_7FFF_0000, 52'h1_0001_000C_0000, 52'h1_0000_0003_0001,
    52'h1_0002_00C0_0040, 52'h1_0002_00C0_0080, 52'h1_0002_00C0_0000,
    52'h1_0001_000C_0004, 52'h1_0001_000C_0000, 52'h0_0102_0030_0000,
    52'h1_0002_0030_0000, 52'h0_0002_0030_0000, 52'h1_0002_0030_0010,
    52'h1_0002_0030_0000, 52'h2_0003_4000_4000, 52'h1_0003_3800_0800,
    52'h1_0002_3800_0000, 52'h2_0003_4000_0000, 52'h1_0000_0003_0000,
    52'h0_0001_0700_0000, 52'h1_0003_0700_0100, 52'h1_0003_0700_0200,
    52'h1_0000_0003_0000, 52'h1_0003_0700_0300, 52'h1_0003_0700_0400,
    52'h1_0003_0700_0000};

  lmpc_panel_model pm (.clk(clk), .key_pins(key_pins), .knob_a(knob_a), .knob_b(knob_b));
  lmpc_top #(.long_press(50), .debounce(4), .blink(8)) dut (.clk(clk), .sys_rst(sys_rst),
    .key_pins(key_pins), .knob_a(knob_a), .knob_b(knob_b), .leds(leds), .digit_cursor(digit_cursor),
    .digit_blink_on(digit_blink_on), .display_quantity(display_quantity), .channel_sel(channel_sel),
    .input_on(input_on), .short_on(short_on), .dynamic_on(dynamic_on), .level_two(level_two),
    .protection_test_start(protection_test_start), .local_level(local_level),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (protection_test_start === 1'b1) prot++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ready and the answer are taken at the rising edge, before its own updates land
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(posedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(posedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 25; i++) begin
      if (rows[i][51:48] == 4'h0) axi_write(lmpc_pkg::ctrl_offset, {16'h0000, rows[i][47:32]});
      else pm.press(rows[i][35:32], rows[i][51:48] == 4'h1 ? 12 : 70);
      axi_read(lmpc_pkg::status_offset);
      check(d & {16'h0000, rows[i][31:16]}, {16'h0000, rows[i][15:0]});
    end
    check(level_two, 2'h0);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0000);
    pm.press(3, 12);
    check({level_two[0], leds.select_led}, 2'h2);
    pm.press(3, 12);
    check({level_two[0], leds.select_led}, 2'h1);
    pm.press(0, 12);
    axi_write(lmpc_pkg::level_offset, 32'h0000_0010);
    check(local_level, 16'h0010);
    pm.turn(1'b1);
    check(local_level, 16'h0011);
    pm.turn(1'b0);
    check(local_level, 16'h0010);
    pm.press(0, 12);
    pm.turn(1'b1);
    check(local_level, 16'h0010);
    axi_write(lmpc_pkg::level_offset, 32'h0000_0020);
    check(local_level, 16'h0020);
    s_axi_wstrb <= 4'h2;
    axi_write(lmpc_pkg::level_offset, 32'h0000_AB00);
    check(local_level, 16'hAB20);
    s_axi_wstrb <= 4'hF;
    // momentary short follows the held key
    pm.press(0, 12);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0004);
    pm.set_key(1, 1'b1);
    repeat (14) @(posedge clk);
    check(short_on[0], 1'b1);
    pm.press(1, 1);
    check(short_on[0], 1'b0);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0008);
    pm.press(1, 12);
    check({prot[3:0], short_on}, 6'h04);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0020);
    axi_write(lmpc_pkg::limit_offset, 32'h0000_0001);
    check({leds.pass_green, leds.pass_red}, 2'h2);
    axi_write(lmpc_pkg::limit_offset, 32'h0000_0000);
    check({leds.pass_green, leds.pass_red}, 2'h1);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0000);
    check({leds.pass_green, leds.pass_red}, 2'h0);
    axi_write(lmpc_pkg::ctrl_offset, 32'h0000_0021);
    pm.press(3, 12);
    pm.press(3, 12);
    axi_write(lmpc_pkg::limit_offset, 32'h0000_0001);
    check({leds.pass_green, leds.pass_red}, 2'h1);
    axi_write(lmpc_pkg::limit_offset, 32'h0000_0003);
    check({leds.pass_green, leds.pass_red, leds.mode_led}, 6'h20);
    check(leds.load_led, 1'b1);
    axi_read(8'h10);
    check({resp, d}, {lmpc_pkg::resp_slverr, 32'h0000_0000});
    axi_write(lmpc_pkg::status_offset, 32'hFFFF_FFFF);
    check(resp, lmpc_pkg::resp_okay);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    axi_read(lmpc_pkg::status_offset);
    check({d[14:0], channel_sel}, 18'h0_0000);
    end_of_test();
  end
endmodule
